// >>> rtl/dcb_ahb_regs.sv
// ahb-lite slave holding the controller registers
`timescale 1ns/1ns
`default_nettype none
`include "dcb_map.svh"
module dcb_ahb_regs
	import dcb_pkg::*;
(
	input wire logic mclk,
	input wire logic srst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	dcb_regs_if.regs rif
);
	logic [11:0] cfg_r;
	logic [11:0] wmask_r;
	logic [95:0] wdata_r;
	logic [31:0] cmd_r;
	logic go_r;
	logic done_r;
	logic err_r;
	logic wen_r;
	logic [7:0] addr_r;
	logic [31:0] hrdata_r;
	logic acc;
	logic [31:0] rd_mux;
	logic we_cfg;
	logic we_cmd;
	logic we_st;
	logic we_msk;
	logic [2:0] we_wd;
	logic [31:0] st_word;

	// address phase taken when selected, ready and a transfer
	assign acc = hsel && hready && htrans[1];
	assign we_cfg = wen_r && (addr_r == `DCB_OFF_CONFIG);
	assign we_cmd = wen_r && (addr_r == `DCB_OFF_CMD);
	assign we_st = wen_r && (addr_r == `DCB_OFF_STATUS);
	assign we_msk = wen_r && (addr_r == `DCB_OFF_WMASK);
	assign we_wd = {wen_r && (addr_r == `DCB_OFF_WDATA2), wen_r && (addr_r == `DCB_OFF_WDATA1),
		wen_r && (addr_r == `DCB_OFF_WDATA0)};
	assign st_word = {29'h0, err_r, done_r, rif.busy};
	assign rd_mux = (haddr[7:0] == `DCB_OFF_CONFIG) ? {20'h0, cfg_r} :
		(haddr[7:0] == `DCB_OFF_CMD) ? cmd_r :
		(haddr[7:0] == `DCB_OFF_STATUS) ? st_word :
		(haddr[7:0] == `DCB_OFF_WMASK) ? {20'h0, wmask_r} :
		(haddr[7:0] == `DCB_OFF_WDATA0) ? wdata_r[31:0] :
		(haddr[7:0] == `DCB_OFF_WDATA1) ? wdata_r[63:32] :
		(haddr[7:0] == `DCB_OFF_WDATA2) ? wdata_r[95:64] :
		(haddr[7:0] == `DCB_OFF_RDATA0) ? rif.rdata[31:0] :
		(haddr[7:0] == `DCB_OFF_RDATA1) ? rif.rdata[63:32] :
		(haddr[7:0] == `DCB_OFF_RDATA2) ? rif.rdata[95:64] : 32'h0;

	always_ff @(posedge mclk) begin
		if (srst) begin
			wen_r <= 1'b0;
			addr_r <= 8'h00;
			hrdata_r <= 32'h0;
		end else begin
			wen_r <= acc && hwrite;
			addr_r <= haddr[7:0];
			hrdata_r <= (acc && !hwrite) ? rd_mux : 32'h0;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			cfg_r <= `DCB_CFG_RESET;
			wmask_r <= 12'h000;
			wdata_r <= 96'h0;
			cmd_r <= 32'h0;
			go_r <= 1'b0;
			done_r <= 1'b0;
			err_r <= 1'b0;
		end else begin
			if (we_cfg) cfg_r <= hwdata[11:0];
			if (we_msk) wmask_r <= hwdata[11:0];
			if (we_wd[0]) wdata_r[31:0] <= hwdata;
			if (we_wd[1]) wdata_r[63:32] <= hwdata;
			if (we_wd[2]) wdata_r[95:64] <= hwdata;
			if (we_cmd) cmd_r <= hwdata;
			go_r <= we_cmd;
			// sticky flags: a new event wins over a write-one clear
			done_r <= rif.done_set || (done_r && !(we_st && hwdata[`DCB_ST_DONE]));
			err_r <= rif.err_set || (err_r && !(we_st && hwdata[`DCB_ST_ERR]));
		end
	end

	assign rif.cl = cfg_r[`DCB_CFG_CL_LSB +: 3];
	assign rif.al = cfg_r[`DCB_CFG_AL_LSB +: 3];
	assign rif.wr = cfg_r[`DCB_CFG_WR_LSB +: 3];
	assign rif.bl8 = cfg_r[`DCB_CFG_BL8];
	assign rif.ilv = cfg_r[`DCB_CFG_ILV];
	assign rif.redundant_read_strobe_en = cfg_r[`DCB_CFG_REDUNDANT_READ_STROBE];
	assign rif.cmd_go = go_r;
	assign rif.cmd = cmd_r;
	assign rif.wmask = wmask_r;
	assign rif.wdata = wdata_r;
	assign hrdata = hrdata_r;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
endmodule // dcb_ahb_regs
`default_nettype wire

// >>> rtl/dcb_ctrl.sv
// column burst controller: ahb registers in, ddr2 command and data pins out
// Behaviour
// (RQ1) column command may precede activate delay
// (RQ2) read latency is additive plus column latency
// (RQ3) write latency is read latency minus one
// (RQ4) early column command needs nonzero additive latency
// (RQ5) burst lengths four and eight only
// (RQ6) burst order picked by mode bit three
// (RQ7) sequential order wraps within nibble
// (RQ8) interleaved order xors start with counter
// (RQ9) never issue a burst terminate
// (RQ10) read data arrives read latency later
// (RQ11) read strobe preamble one clock low
// (RQ12) read data edge aligned with strobe
// (RQ13) write strobe preamble half clock early
// (RQ14) exactly burst words written, rest ignored
// (RQ15) write recovery before precharge
// (RQ16) one mask bit per byte, data timing
// (RQ17) mask off when redundant strobe enabled
// (RQ18) no interrupt with burst length four
// (RQ19) interrupt only same direction at eight
// (RQ20) interrupt exactly two clocks, truncates four
// (RQ21) interrupt any bank, never auto precharge
// (RQ22) interrupter may carry auto precharge
// (RQ23) timings follow programmed, not truncated burst
// (RQ24) column commands at least two clocks apart
// (RQ25) burst stays inside aligned column group
// (RQ26) masked byte left unchanged in array
//
// The AHB-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "dcb_map.svh"
module dcb_ctrl
	import dcb_pkg::*;
(
	input wire logic mclk,
	input wire logic srst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic ck,
	output logic ck_n,
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic [1:0] ba,
	output logic [12:0] addr,
	output logic [7:0] dq_o,
	output logic dq_oe,
	input wire logic [7:0] dq_i,
	output logic dqs_o,
	output logic dqs_oe,
	input wire logic dqs_i,
	output logic write_mask
);
	dcb_regs_if rif();

	dcb_ahb_regs u_regs (
		.mclk(mclk),
		.srst(srst),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hrdata(hrdata),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.rif(rif.regs)
	);

	logic [8:0] pin_s;

	dcb_pin_sync u_sync (
		.mclk(mclk),
		.srst(srst),
		.d({dqs_i, dq_i}),
		.q(pin_s)
	);

	dcb_state_type state_r;
	logic [1:0] ph_r;
	logic ck_r;
	logic pend_r;
	logic [31:0] cmd_r;
	logic [8:0] q_r;
	logic cs_n_r;
	logic [2:0] rcw_r;
	logic [1:0] ba_r;
	logic [12:0] addr_r;
	logic [7:0] dq_r;
	logic dq_oe_r;
	logic dqs_r;
	logic dqs_oe_r;
	logic dm_r;
	logic dqs_d_r;
	logic cap_r;
	logic [3:0] rcnt_r;
	logic [7:0] rbuf [0:11];
	logic [3:0] wedge_r;
	logic dqs_q_r;

	logic dqs_s;
	logic [7:0] dq_s;
	logic wdir;
	logic chain;
	logic [3:0] rl;
	logic [3:0] wl;
	logic [3:0] ncols;
	logic [3:0] nwords;
	logic [3:0] last_ck;
	logic [8:0] base_w;
	logic [8:0] base_r;
	logic [8:0] rec_end;
	logic [8:0] w_pre;
	logic [8:0] w_last;
	logic [8:0] w_post;
	logic [8:0] w_rel;
	logic [8:0] m_full;
	logic [3:0] beat;
	logic [8:0] r_arm;
	logic [8:0] q_nxt;
	logic chain_bad;
	logic early_bad;
	logic refuse;
	logic accept;
	logic launch;
	logic wr_end;
	logic rd_end;
	logic end_run;
	logic run_nxt;
	logic sel1;
	logic sel2;
	logic w_on;
	logic dq_win;
	logic arm;
	logic rd_edge;

	assign dqs_s = pin_s[8];
	assign dq_s = pin_s[7:0];
	assign wdir = cmd_r[`DCB_CMD_WRITE];
	assign chain = cmd_r[`DCB_CMD_CHAIN];

	// refusals: bad interrupt request, early command without additive latency, or busy
	assign chain_bad = rif.cmd[`DCB_CMD_CHAIN] && (!rif.bl8 || rif.cmd[`DCB_CMD_AP]); // RQ18 RQ19 RQ21
	assign early_bad = rif.cmd[`DCB_CMD_EARLY] && (rif.al == 3'h0); // RQ1 RQ4
	assign refuse = rif.cmd_go && (rif.busy || chain_bad || early_bad); // RQ24
	assign accept = rif.cmd_go && !refuse;

	// latencies and burst sizes
	assign rl = {1'b0, rif.al} + {1'b0, rif.cl}; // RQ2
	assign wl = rl - `DCB_WL_LESS; // RQ3
	assign ncols = rif.bl8 ? `DCB_BL_LONG : `DCB_BL_SHORT; // RQ5
	assign nwords = chain ? ncols + `DCB_BL_SHORT : ncols; // RQ20
	assign last_ck = chain ? 4'(`DCB_CCD_CK) : 4'h0;
	assign base_w = 9'(`DCB_HALF + `DCB_TICKS * wl); // RQ3
	assign base_r = 9'(`DCB_HALF + `DCB_TICKS * rl); // RQ10
	assign rec_end = 9'(`DCB_HALF + `DCB_TICKS * (last_ck + wl + ncols / 2 + rif.wr)); // RQ15 RQ23
	assign w_pre = 9'(base_w - `DCB_HALF);
	assign w_last = 9'(base_w + `DCB_HALF * nwords - `DCB_QUARTER);
	assign w_post = 9'(w_last + `DCB_HALF);
	assign r_arm = 9'(base_r - `DCB_HALF); // RQ11

	// sequencing
	assign launch = (state_r == DCB_IDLE) && pend_r && (ph_r == `DCB_PH_LAUNCH);
	assign wr_end = wdir && (q_r == rec_end); // RQ15 RQ23
	assign rd_end = !wdir && (rcnt_r == nwords) && !cap_r;
	assign end_run = (state_r == DCB_RUN) && (wr_end || rd_end);
	assign run_nxt = launch || ((state_r == DCB_RUN) && !end_run);
	assign q_nxt = launch ? 9'h000 : 9'(q_r + 9'h001);

	// command slots: first at q 0..3, interrupting one two clocks later
	assign sel1 = run_nxt && dcb_in(q_nxt, 9'h000, 9'(`DCB_TICKS - 1));
	assign sel2 = run_nxt && chain && dcb_in(q_nxt, 9'(`DCB_TICKS * `DCB_CCD_CK),
		9'(`DCB_TICKS * `DCB_CCD_CK + `DCB_TICKS - 1)); // RQ20 RQ22

	// write strobe and data windows
	assign w_on = run_nxt && wdir;
	assign w_rel = 9'(q_nxt - base_w);
	assign m_full = 9'(q_nxt - base_w + `DCB_QUARTER);
	assign beat = m_full[4:1];
	assign dq_win = w_on && dcb_in(q_nxt, 9'(base_w - `DCB_QUARTER), 9'(w_last - `DCB_QUARTER)); // RQ14

	// read capture on each strobe transition after the preamble
	assign arm = (state_r == DCB_RUN) && !wdir && (q_r >= r_arm) && (rcnt_r < nwords); // RQ11
	assign rd_edge = dqs_s ^ dqs_d_r;

	always_ff @(posedge mclk) begin
		if (srst) begin
			state_r <= DCB_IDLE;
			ph_r <= 2'h0;
			ck_r <= 1'b0;
			pend_r <= 1'b0;
			cmd_r <= 32'h0;
			q_r <= 9'h000;
		end else begin
			state_r <= run_nxt ? DCB_RUN : DCB_IDLE;
			ph_r <= 2'(ph_r + 2'h1);
			// ck high in phases 0 and 1, so it rises in the middle of a held command
			ck_r <= !(ph_r[0] ^ ph_r[1]);
			pend_r <= accept || (pend_r && !launch);
			if (accept) cmd_r <= rif.cmd;
			q_r <= run_nxt ? q_nxt : 9'h000;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			cs_n_r <= 1'b1;
			rcw_r <= `DCB_RCW_NOP;
			ba_r <= 2'h0;
			addr_r <= 13'h0000;
		end else begin
			cs_n_r <= !(sel1 || sel2);
			// only read, write or nop codes are ever driven
			rcw_r <= (sel1 || sel2) ? (wdir ? `DCB_RCW_WRITE : `DCB_RCW_READ) : `DCB_RCW_NOP; // RQ9
			ba_r <= sel2 ? cmd_r[`DCB_CMD_BANK2_LSB +: 2] : cmd_r[`DCB_CMD_BANK_LSB +: 2]; // RQ21
			addr_r <= sel2 ? {2'h0, cmd_r[`DCB_CMD_AP2], cmd_r[`DCB_CMD_COL2_LSB +: `DCB_COL_W]} :
				{2'h0, cmd_r[`DCB_CMD_AP], cmd_r[`DCB_CMD_COL_LSB +: `DCB_COL_W]}; // RQ22
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			dqs_oe_r <= 1'b0;
			dqs_r <= 1'b0;
			dq_oe_r <= 1'b0;
			dq_r <= 8'h00;
			dm_r <= 1'b0;
		end else begin
			dqs_oe_r <= w_on && dcb_in(q_nxt, w_pre, w_post); // RQ13
			dqs_r <= w_on && dcb_in(q_nxt, base_w, w_last) && !w_rel[1]; // RQ13 RQ14
			dq_oe_r <= dq_win; // RQ14
			dq_r <= dq_win ? rif.wdata[beat * 8 +: 8] : 8'h00;
			dm_r <= dq_win && rif.wmask[beat] && !rif.redundant_read_strobe_en; // RQ16 RQ17
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			dqs_d_r <= 1'b0;
			cap_r <= 1'b0;
			rcnt_r <= 4'h0;
			for (int i = 0; i < 12; i++) rbuf[i] <= 8'h00;
		end else begin
			dqs_d_r <= dqs_s;
			cap_r <= arm && rd_edge; // RQ12
			if (launch) rcnt_r <= 4'h0;
			else if (cap_r) rcnt_r <= 4'(rcnt_r + 4'h1);
			if (cap_r) rbuf[rcnt_r] <= dq_s; // RQ10 RQ12
		end
	end

	for (genvar g = 0; g < 12; g++) begin : g_rd
		assign rif.rdata[g * 8 +: 8] = rbuf[g];
	end

	assign rif.busy = pend_r || (state_r == DCB_RUN);
	assign rif.done_set = end_run;
	assign rif.err_set = refuse;

	assign ck = ck_r;
	assign ck_n = !ck_r;
	assign cs_n = cs_n_r;
	assign ras_n = rcw_r[2];
	assign cas_n = rcw_r[1];
	assign we_n = rcw_r[0];
	assign ba = ba_r;
	assign addr = addr_r;
	assign dq_o = dq_r;
	assign dq_oe = dq_oe_r;
	assign dqs_o = dqs_r;
	assign dqs_oe = dqs_oe_r;
	assign write_mask = dm_r;

	// helper: strobe edges driven during a write
	always_ff @(posedge mclk) begin
		if (srst) begin
			dqs_q_r <= 1'b0;
			wedge_r <= 4'h0;
		end else begin
			dqs_q_r <= dqs_r;
			if (launch) wedge_r <= 4'h0;
			else if (dqs_r != dqs_q_r) wedge_r <= 4'(wedge_r + 4'h1);
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	a_chain_spacing: assert property ($fell(cs_n_r) && q_r == 9'h000 && chain |-> ##8 $fell(cs_n_r)) // RQ20
		else $error("interrupting command not two clocks after first");
	a_no_terminate: assert property (!cs_n_r |-> !cas_n && ras_n) // RQ9
		else $error("non column command driven");
	a_wr_preamble: assert property ($rose(dqs_oe_r) |-> !dqs_r [*2] ##1 dqs_r) // RQ13
		else $error("write preamble not half clock low");
	a_wr_latency: assert property (state_r == DCB_RUN && wdir && q_r == base_w |-> dqs_r && !$past(dqs_r)) // RQ3
		else $error("first write strobe not at write latency");
	a_mask_redundant_read_strobe: assert property (rif.redundant_read_strobe_en && dq_oe_r |-> !dm_r) // RQ17
		else $error("mask driven with redundant strobe on");
	a_bl4_chain: assert property (rif.cmd_go && rif.cmd[`DCB_CMD_CHAIN] && !rif.bl8 && !rif.busy |=> !pend_r) // RQ18
		else $error("interrupt accepted at burst length four");
	a_early_al: assert property (rif.cmd_go && rif.cmd[`DCB_CMD_EARLY] && rif.al == 3'h0 && !rif.busy |=> !pend_r) // RQ4
		else $error("early command accepted without additive latency");
	a_wr_beats: assert property ($fell(dqs_oe_r) |-> wedge_r == nwords) // RQ14
		else $error("write strobe edge count wrong");
	a_rd_words: assert property (end_run && !wdir |-> rcnt_r == nwords ##1 state_r == DCB_IDLE) // RQ10
		else $error("read ended with wrong word count");
	a_wr_recover: assert property (end_run && wdir |-> q_r == rec_end && !dqs_oe_r) // RQ15 RQ23
		else $error("write ended before recovery");
endmodule // dcb_ctrl
`default_nettype wire

// >>> rtl/dcb_map.svh
// register map, field positions and timing constants of the column burst controller
`ifndef DCB_MAP_SVH
`define DCB_MAP_SVH

`define DCB_OFF_CONFIG 8'h00
`define DCB_OFF_CMD 8'h04
`define DCB_OFF_STATUS 8'h08
`define DCB_OFF_WMASK 8'h0c
`define DCB_OFF_WDATA0 8'h10
`define DCB_OFF_WDATA1 8'h14
`define DCB_OFF_WDATA2 8'h18
`define DCB_OFF_RDATA0 8'h1c
`define DCB_OFF_RDATA1 8'h20
`define DCB_OFF_RDATA2 8'h24

`define DCB_CFG_RESET 12'h603
`define DCB_CFG_CL_LSB 0
`define DCB_CFG_AL_LSB 3
`define DCB_CFG_BL8 6
`define DCB_CFG_ILV 7
`define DCB_CFG_REDUNDANT_READ_STROBE 8
`define DCB_CFG_WR_LSB 9

`define DCB_CMD_WRITE 0
`define DCB_CMD_AP 1
`define DCB_CMD_BANK_LSB 2
`define DCB_CMD_COL_LSB 4
`define DCB_CMD_CHAIN 14
`define DCB_CMD_AP2 15
`define DCB_CMD_BANK2_LSB 16
`define DCB_CMD_COL2_LSB 18
`define DCB_CMD_EARLY 28
`define DCB_COL_W 10

`define DCB_ST_BUSY 0
`define DCB_ST_DONE 1
`define DCB_ST_ERR 2

`define DCB_RCW_READ 3'h5
`define DCB_RCW_WRITE 3'h4
`define DCB_RCW_NOP 3'h7

`define DCB_MCLK_NS 4
`define DCB_CK_NS 16
`define DCB_TICKS (`DCB_CK_NS / `DCB_MCLK_NS)
`define DCB_HALF (`DCB_TICKS / 2)
`define DCB_QUARTER (`DCB_TICKS / 4)
`define DCB_PH_LAUNCH 2'h1
`define DCB_CCD_CK 2
`define DCB_BL_SHORT 4'h4
`define DCB_BL_LONG 4'h8
`define DCB_WL_LESS 4'h1

`endif

// >>> rtl/dcb_pin_sync.sv
// two-flop synchroniser for the data and strobe pins
`timescale 1ns/1ns
`default_nettype none
module dcb_pin_sync (
	input wire logic mclk,
	input wire logic srst,
	input wire logic [8:0] d,
	output logic [8:0] q
);
	logic [8:0] meta_r;
	logic [8:0] q_r;

	always_ff @(posedge mclk) begin
		if (srst) begin
			meta_r <= 9'h000;
			q_r <= 9'h000;
		end else begin
			meta_r <= d;
			q_r <= meta_r;
		end
	end

	assign q = q_r;
endmodule // dcb_pin_sync
`default_nettype wire

// >>> rtl/dcb_pkg.sv
// types and helper functions of the column burst controller
package dcb_pkg;

	typedef enum {DCB_IDLE, DCB_RUN} dcb_state_type;

	function automatic logic dcb_in(input logic [8:0] q, input logic [8:0] lo, input logic [8:0] hi);
		return (q >= lo) && (q <= hi);
	endfunction

endpackage

// >>> rtl/dcb_regs_if.sv
// interface between register file and burst engine
`timescale 1ns/1ns
`default_nettype none
interface dcb_regs_if;
	logic [2:0] cl;
	logic [2:0] al;
	logic [2:0] wr;
	logic bl8;
	logic ilv;
	logic redundant_read_strobe_en;
	logic cmd_go;
	logic [31:0] cmd;
	logic [11:0] wmask;
	logic [95:0] wdata;
	logic [95:0] rdata;
	logic busy;
	logic done_set;
	logic err_set;
	modport regs (output cl, al, wr, bl8, ilv, redundant_read_strobe_en, cmd_go, cmd, wmask, wdata,
		input rdata, busy, done_set, err_set);
	modport core (input cl, al, wr, bl8, ilv, redundant_read_strobe_en, cmd_go, cmd, wmask, wdata,
		output rdata, busy, done_set, err_set);
endinterface
`default_nettype wire

// >>> tb/dcb_dev_model.sv
// behavioural ddr2 device: column commands, burst order, read and write data
`timescale 1ns/1ns
`default_nettype none
module dcb_dev_model
	import dcb_tb_pkg::*;
(
	input wire logic ck,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [1:0] ba,
	input wire logic [12:0] addr,
	input wire logic [7:0] dq,
	input wire logic dqs,
	input wire logic dqs_h_oe,
	input wire logic wmask,
	input wire logic [2:0] al,
	input wire logic [2:0] cl,
	input wire logic bl8,
	input wire logic ilv,
	input wire logic redundant_read_strobe,
	output logic [7:0] dq_r,
	output logic dqs_r,
	output logic [7:0] faults
);
	logic [7:0] mem [0:4095];
	logic [11:0] rslot [int];
	logic [11:0] wslot [int];
	logic w_r;
	logic lw_r;
	logic lap_r;
	int s = 0;
	int lt = -9;
	int nf = 0;
	int d;
	wire logic [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
	assign faults = nf[7:0];
	initial begin
		for (int i = 0; i < 4096; i++) begin
			mem[i] = dcb_seed(i);
		end
		dq_r = 8'h00;
		dqs_r = 1'b0;
	end
	// slot counter: even slots at rising ck, odd at falling ck
	always @(posedge ck or negedge ck) begin
		if (ck === 1'b1) begin
			s = (s | 1) + 1;
		end else begin
			s = (s + 1) | 1;
		end
		if (rslot.exists(s)) begin
			dq_r = mem[rslot[s]];
			dqs_r = ~s[0];
			rslot.delete(s);
		end else begin
			dq_r = ~dq_r;
			dqs_r = 1'b0;
		end
		if (ck === 1'b1 && cmd == 4'b0110) begin
			nf++;
		end
		if (ck === 1'b1 && (cmd == 4'b0101 || cmd == 4'b0100)) begin
			d = s / 2 - lt;
			w_r = ~we_n;
			if (d < 2) begin
				nf++;
			end
			if (bl8 && d < 4 && (d != 2 || w_r != lw_r || lap_r)) begin
				nf++;
			end
			// a later burst overwrites the tail slots, truncating the earlier one
			for (int i = 0; i < (bl8 ? 8 : 4); i++) begin
				if (w_r) begin
					wslot[s + 2 * (int'(al) + int'(cl) - 1) + i] = {ba, dcb_ord(addr[9:0], i, bl8, ilv)};
				end else begin
					rslot[s + 2 * (int'(al) + int'(cl)) + i] = {ba, dcb_ord(addr[9:0], i, bl8, ilv)};
				end
			end
			lt = s / 2;
			lw_r = w_r;
			lap_r = addr[10];
		end
		#1;
		if (wslot.exists(s)) begin
			if (!dqs_h_oe || dqs !== ~s[0]) begin
				nf++;
			end
			if (!wmask || redundant_read_strobe) begin
				mem[wslot[s]] = dq;
			end
			wslot.delete(s);
		end else if (wslot.exists(s + 1) && (!dqs_h_oe || dqs !== 1'b0)) begin
			nf++;
		end
	end
endmodule // dcb_dev_model
`default_nettype wire

// >>> tb/dcb_tb_pkg.sv
// bench helpers: burst column order and initial array contents
package dcb_tb_pkg;

	function automatic logic [9:0] dcb_ord(input logic [9:0] c, input int i, input logic b8, input logic il);
		logic [2:0] k;
		k = il ? (c[2:0] ^ i[2:0]) : {c[2] ^ i[2], c[1:0] + i[1:0]};
		return b8 ? {c[9:3], k} : {c[9:2], k[1:0]};
	endfunction

	function automatic logic [7:0] dcb_seed(input int a);
		return a[7:0] ^ a[11:4];
	endfunction

endpackage

// >>> tb/tb.sv
// testbench: ahb register access and burst traffic against the device model
`timescale 1ns/1ns
`default_nettype none
`include "dcb_map.svh"
module tb;
	import dcb_tb_pkg::*;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout, hresp, ck, ck_n, cs_n, ras_n, cas_n, we_n, dq_oe, dqs_o, dqs_oe, dqs_r, wmask;
	logic [1:0] ba;
	logic [12:0] addr;
	logic [7:0] dq_o, dq_r, faults;
	logic [2:0] m_cl = 3'h3;
	logic [2:0] m_al = 3'h0;
	logic m_bl8 = 1'b0;
	logic m_ilv = 1'b0;
	logic m_redundant_read_strobe = 1'b0;
	logic [7:0] pat = 8'h00;
	logic [7:0] sh [0:4095];
	int err_count = 0;
	int total_checks = 0;
	int cyc = 0;
	int t_cmd = 0;
	logic cs_n_q = 1'b1;
	wire logic [7:0] dq_i = dq_oe ? dq_o : dq_r;
	wire logic dqs_i = dqs_oe ? dqs_o : dqs_r;
	always #2 mclk = ~mclk;
	// cycle count and the cycle in which the latest column command was first driven
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		cs_n_q <= cs_n;
		if (cs_n === 1'b0 && cs_n_q === 1'b1) begin
			t_cmd <= cyc;
		end
	end
	dcb_ctrl dcb_ctrl_i (.mclk(mclk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.ck(ck), .ck_n(ck_n), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr),
		.dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i), .dqs_o(dqs_o), .dqs_oe(dqs_oe), .dqs_i(dqs_i), .write_mask(wmask));
	dcb_dev_model dcb_dev_model_i (.ck(ck), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
		.addr(addr), .dq(dq_i), .dqs(dqs_i), .dqs_h_oe(dqs_oe), .wmask(wmask), .al(m_al), .cl(m_cl), .bl8(m_bl8),
		.ilv(m_ilv), .redundant_read_strobe(m_redundant_read_strobe), .dq_r(dq_r), .dqs_r(dqs_r), .faults(faults));
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic ahb(input logic wr_en, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr_en;
		haddr <= {24'h0, a};
		@(posedge mclk);
		while (hreadyout !== 1'b1) begin
			@(posedge mclk);
		end
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge mclk);
		while (hreadyout !== 1'b1) begin
			@(posedge mclk);
		end
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		ahb(1'b1, a, d, q);
	endtask
	task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		ahb(1'b0, a, 32'h0, q);
		chk(n, e, q);
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask
	task automatic cfg(input logic [2:0] cl, input logic [2:0] al, input logic b8, input logic il, input logic rq);
		m_cl <= cl;
		m_al <= al;
		m_bl8 <= b8;
		m_ilv <= il;
		m_redundant_read_strobe <= rq;
		wr(`DCB_OFF_CONFIG, {20'h0, 3'h3, rq, il, b8, al, cl});
		rchk("config", `DCB_OFF_CONFIG, {20'h0, 3'h3, rq, il, b8, al, cl});
	endtask
	function automatic logic [31:0] mk(input logic [4:0] f, input logic [1:0] b, input logic [9:0] c,
		input logic [1:0] b2, input logic [9:0] c2);
		return {3'h0, f[4], c2, b2, f[2], f[3], c, b, f[1], f[0]};
	endfunction
	task automatic xfer(input logic [31:0] cw, input logic xe, input logic [11:0] m);
		logic [31:0] q;
		logic [11:0] a [12];
		logic [7:0] d [12];
		int n;
		int k;
		int e;
		n = (cw[14] ? 4 : 0) + (m_bl8 ? 8 : 4);
		for (k = 0; k < 12; k++) begin
			a[k] = (!cw[14] || k < 4) ? {cw[3:2], dcb_ord(cw[13:4], k, m_bl8, m_ilv)}
				: {cw[17:16], dcb_ord(cw[27:18], k - 4, m_bl8, m_ilv)};
			d[k] = pat + 8'(k);
		end
		pat = pat + 8'h1d;
		if (cw[0]) begin
			wr(`DCB_OFF_WMASK, {20'h0, m});
			for (k = 0; k < 3; k++) begin
				wr(`DCB_OFF_WDATA0 + 8'(4 * k), {d[4 * k + 3], d[4 * k + 2], d[4 * k + 1], d[4 * k]});
			end
		end
		wr(`DCB_OFF_CMD, cw);
		k = 0;
		q = 32'h0;
		while (q[2:1] == 2'h0 && k < 400) begin
			ahb(1'b0, `DCB_OFF_STATUS, 32'h0, q);
			k++;
		end
		chk("status", xe ? 32'h4 : 32'h2, q);
		if (cw[0] && !xe) begin
			// write latency, programmed burst and recovery of 3 clocks; status path adds 4 or 5 cycles
			e = `DCB_TICKS * (int'(m_al) + int'(m_cl) - 1 + (m_bl8 ? 4 : 2) + 3) + 4;
			chk("write recovery", 32'h1, {31'h0, cyc - t_cmd >= e && cyc - t_cmd <= e + 1});
		end
		wr(`DCB_OFF_STATUS, 32'h6);
		for (k = 0; k < n && !xe; k++) begin
			if (cw[0] && (!m[k] || m_redundant_read_strobe)) begin
				sh[a[k]] = d[k];
			end else if (!cw[0]) begin
				if (k % 4 == 0) begin
					ahb(1'b0, `DCB_OFF_RDATA0 + 8'(k), 32'h0, q);
				end
				chk("read beat", {24'h0, sh[a[k]]}, {24'h0, q[8 * (k % 4) +: 8]});
			end
		end
	endtask
	initial begin
		#100000;
		err_count++;
		report_and_stop();
	end
	initial begin
		for (int i = 0; i < 4096; i++) begin
			sh[i] = dcb_seed(i);
		end
		repeat (20) @(posedge mclk);
		srst <= 1'b0;
		repeat (2) @(posedge mclk);
		rchk("config reset", `DCB_OFF_CONFIG, 32'h603);
		rchk("status reset", `DCB_OFF_STATUS, 32'h0);
		wr(8'h40, 32'hffffffff);
		rchk("unmapped", 8'h40, 32'h0);
		cfg(3'h3, 3'h0, 1'b0, 1'b0, 1'b0);
		xfer(mk(5'h00, 2'h0, 10'h001, 2'h0, 10'h000), 1'b0, 12'h000);
		xfer(mk(5'h01, 2'h2, 10'h006, 2'h0, 10'h000), 1'b0, 12'h002);
		xfer(mk(5'h00, 2'h2, 10'h006, 2'h0, 10'h000), 1'b0, 12'h000);
		xfer(mk(5'h08, 2'h0, 10'h004, 2'h1, 10'h008), 1'b1, 12'h000);
		for (int il = 0; il < 2; il++) begin
			cfg(3'h3, 3'h0, 1'b1, il[0], 1'b0);
			xfer(mk(5'h00, 2'h1, 10'h3fd, 2'h0, 10'h000), 1'b0, 12'h000);
			xfer(mk(5'h01, 2'h1, 10'h00b, 2'h0, 10'h000), 1'b0, 12'h090);
			xfer(mk(5'h00, 2'h1, 10'h00b, 2'h0, 10'h000), 1'b0, 12'h000);
		end
		xfer(mk(5'h0c, 2'h0, 10'h002, 2'h3, 10'h109), 1'b0, 12'h000);
		xfer(mk(5'h0d, 2'h1, 10'h00c, 2'h1, 10'h014), 1'b0, 12'h021);
		xfer(mk(5'h00, 2'h1, 10'h00c, 2'h0, 10'h000), 1'b0, 12'h000);
		xfer(mk(5'h00, 2'h1, 10'h014, 2'h0, 10'h000), 1'b0, 12'h000);
		xfer(mk(5'h0a, 2'h0, 10'h000, 2'h1, 10'h008), 1'b1, 12'h000);
		xfer(mk(5'h10, 2'h0, 10'h000, 2'h0, 10'h000), 1'b1, 12'h000);
		cfg(3'h4, 3'h2, 1'b0, 1'b0, 1'b1);
		xfer(mk(5'h10, 2'h3, 10'h022, 2'h0, 10'h000), 1'b0, 12'h000);
		xfer(mk(5'h11, 2'h3, 10'h022, 2'h0, 10'h000), 1'b0, 12'h00f);
		xfer(mk(5'h10, 2'h3, 10'h022, 2'h0, 10'h000), 1'b0, 12'h000);
		chk("device faults", 32'h0, {24'h0, faults});
		chk("ck pair", {31'h0, ~ck}, {31'h0, ck_n});
		report_and_stop();
	end
endmodule // tb
`default_nettype wire
